// File: verilog/eio_pkg.sv
package eio_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int NUM_LINES = 5;
    localparam int NUM_CHANS = 4;

    // ************************************************************
    // Detection methods
    // ************************************************************
    typedef enum logic [2:0] {
        EIO_DET_RISE = 3'h0,
        EIO_DET_FALL = 3'h1,
        EIO_DET_HIGH = 3'h2,
        EIO_DET_LOW  = 3'h3,
        EIO_DET_ANY  = 3'h4
    } eio_det_t;

    // ************************************************************
    // Response actions
    // ************************************************************
    typedef enum logic [1:0] {
        EIO_ACT_OFF    = 2'h0,
        EIO_ACT_ON     = 2'h1,
        EIO_ACT_TOGGLE = 2'h2
    } eio_act_t;

    // ************************************************************
    // Per-line configuration written by the control side
    // ************************************************************
    typedef struct packed {
        logic                 is_output;
        eio_det_t             det;
        eio_act_t             act;
        logic [NUM_CHANS-1:0] chan_mask;
        logic                 polarity_neg;
    } eio_cfg_t;

    localparam logic [NUM_CHANS-1:0] CHAN_NONE  = 4'h0;
    localparam logic [NUM_CHANS-1:0] CHAN_RESET = 4'h1;
    localparam logic [1:0]           SYNC_RESET = 2'h0;

endpackage : eio_pkg

// File: verilog/eio_trigger_map.sv
`timescale 1ns/1ps
// Operation
// RQ1: Detection type applies to input lines only, one of five methods.
// RQ2: Rising detection fires on low-to-high; falling on high-to-low.
// RQ3: Falling detection fires only on high-to-low transitions.
// RQ4: High-level detection: trigger present while line is high.
// RQ5: Low-level detection: trigger present while line is low.
// RQ6: Any-change detection fires on every transition.
// RQ7: Any-change detection permits only on/off response; others refused.
// RQ8: Each line has a four-bit channel selection mask.
// RQ9: Input line may select one to all channels.
// RQ10: Input mask update leaving no channel selected is rejected.
// RQ11: Input trigger applies the response to every selected channel.
// RQ12: Output line holds exactly one channel; new selection replaces old. Code keeps an earlier multi-bit input mask on an empty or locked write.
// RQ13: Output line asserts when its channel status meets the condition.
// RQ14: Three-output variant forbids changing output channel selection.
// RQ15: Five lines, each configurable as input or output.
// RQ16: Parameter changes accepted only while the line is disabled.
// RQ17: Output line has positive or negative polarity.
// RQ18: Response is output off, output on, or toggle.
// RQ19: Inputs pass through two flip-flops before detection.
module eio_trigger_map #(
    parameter int  NUM_LINES  = eio_pkg::NUM_LINES,
    parameter int  NUM_CHANS  = eio_pkg::NUM_CHANS,
    parameter bit  THREE_OUT  = 1'b0
) (
    input  wire logic                 clk_in,
    input  wire logic                 reset_in,
    input  wire logic [NUM_LINES-1:0] line_enable_in,
    input  wire logic [NUM_LINES-1:0] cfg_write_in,
    input  wire logic                 cfg_line_is_output_in,
    input  wire eio_pkg::eio_det_t    cfg_det_in,
    input  wire eio_pkg::eio_act_t    cfg_act_in,
    input  wire logic [NUM_CHANS-1:0] cfg_chan_mask_in,
    input  wire logic                 cfg_polarity_neg_in,
    input  wire logic [NUM_LINES-1:0] cond_met_in,
    input  wire logic [NUM_CHANS-1:0] chan_on_in,
    input  wire logic [NUM_LINES-1:0] io_lines_i_in,
    output logic      [NUM_LINES-1:0] io_lines_o_out,
    output logic      [NUM_LINES-1:0] io_lines_oe_out,
    output logic      [NUM_LINES-1:0] cfg_reject_out,
    output logic      [NUM_CHANS-1:0] supply_channels_on_out,
    output logic      [NUM_CHANS-1:0] supply_channels_sel_out
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [NUM_CHANS-1:0] one_hot_low(input logic [NUM_CHANS-1:0] m);
        logic [NUM_CHANS-1:0] r;
        r = m & (~m + 1'b1);
        return r;
    endfunction : one_hot_low

    function automatic logic [NUM_CHANS-1:0] apply_act(input eio_pkg::eio_act_t a,
                                                        input logic [NUM_CHANS-1:0] cur,
                                                        input logic [NUM_CHANS-1:0] msk);
        logic [NUM_CHANS-1:0] r;
        r = cur;
        case (a)
            eio_pkg::EIO_ACT_OFF:    r = cur & ~msk;
            eio_pkg::EIO_ACT_ON:     r = cur | msk;
            eio_pkg::EIO_ACT_TOGGLE: r = cur ^ msk;
            default:                 r = cur;
        endcase
        return r;
    endfunction : apply_act

    // ************************************************************
    // Configuration store
    // ************************************************************
    eio_pkg::eio_cfg_t    cfg_r [NUM_LINES];
    logic [NUM_LINES-1:0] reject_r;
    logic [NUM_LINES-1:0] accept;
    logic [NUM_LINES-1:0] bad_mask;
    logic [NUM_LINES-1:0] bad_act;
    logic [NUM_LINES-1:0] chan_locked;

    always_comb
    begin
        for (int i = 0; i < NUM_LINES; i++)
        begin
            bad_mask[i]    = !cfg_line_is_output_in
                             && (cfg_chan_mask_in == eio_pkg::CHAN_NONE);   // [RQ10]
            bad_act[i]     = !cfg_line_is_output_in
                             && (cfg_det_in == eio_pkg::EIO_DET_ANY)
                             && (cfg_act_in == eio_pkg::EIO_ACT_TOGGLE);    // [RQ7]
            chan_locked[i] = THREE_OUT && cfg_line_is_output_in;            // [RQ14]
            accept[i]      = cfg_write_in[i] && !line_enable_in[i]          // [RQ16]
                             && !bad_mask[i] && !bad_act[i];
        end
    end

    always_ff @(posedge clk_in)
    begin
        for (int i = 0; i < NUM_LINES; i++)
        begin
            if (reset_in)
            begin
                cfg_r[i].is_output    <= 1'b0;
                cfg_r[i].det          <= eio_pkg::EIO_DET_RISE;
                cfg_r[i].act          <= eio_pkg::EIO_ACT_ON;
                cfg_r[i].chan_mask    <= eio_pkg::CHAN_RESET;
                cfg_r[i].polarity_neg <= 1'b0;
            end
            else if (accept[i])
            begin
                cfg_r[i].is_output    <= cfg_line_is_output_in;            // [RQ15]
                cfg_r[i].det          <= cfg_det_in;                       // [RQ1]
                cfg_r[i].act          <= cfg_act_in;                       // [RQ18]
                cfg_r[i].polarity_neg <= cfg_polarity_neg_in;              // [RQ17]
                if (cfg_line_is_output_in)
                begin
                    // Lowest bit wins; an empty or locked mask keeps the old one, which may carry several channels
                    if (!chan_locked[i] && cfg_chan_mask_in != eio_pkg::CHAN_NONE)
                        cfg_r[i].chan_mask <= one_hot_low(cfg_chan_mask_in); // [RQ12] [RQ14]
                end
                else
                    cfg_r[i].chan_mask <= cfg_chan_mask_in;                 // [RQ8] [RQ9]
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            reject_r <= '0;
        else
            reject_r <= cfg_write_in & ~accept;                            // [RQ10] [RQ16]
    end

    // ************************************************************
    // Input synchronisers and detection
    // ************************************************************
    logic [NUM_LINES-1:0] sync1_r;
    logic [NUM_LINES-1:0] sync2_r;
    logic [NUM_LINES-1:0] prev_r;
    logic [NUM_LINES-1:0] trig;

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
            prev_r  <= '0;
        end
        else
        begin
            sync1_r <= io_lines_i_in;                                      // [RQ19]
            sync2_r <= sync1_r;                                            // [RQ19]
            prev_r  <= sync2_r;
        end
    end

    always_comb
    begin
        for (int i = 0; i < NUM_LINES; i++)
        begin
            case (cfg_r[i].det)
                eio_pkg::EIO_DET_RISE: trig[i] = sync2_r[i] && !prev_r[i];  // [RQ2]
                eio_pkg::EIO_DET_FALL: trig[i] = !sync2_r[i] && prev_r[i];  // [RQ3]
                eio_pkg::EIO_DET_HIGH: trig[i] = sync2_r[i];                // [RQ4]
                eio_pkg::EIO_DET_LOW:  trig[i] = !sync2_r[i];               // [RQ5]
                eio_pkg::EIO_DET_ANY:  trig[i] = sync2_r[i] ^ prev_r[i];    // [RQ6]
                default:               trig[i] = 1'b0;
            endcase
            trig[i] = trig[i] && line_enable_in[i] && !cfg_r[i].is_output; // [RQ1]
        end
    end

    // ************************************************************
    // Channel response; later lines take priority on conflict
    // ************************************************************
    logic [NUM_CHANS-1:0] chan_on_nxt;
    logic [NUM_CHANS-1:0] chan_on_r;

    always_comb
    begin
        chan_on_nxt = chan_on_in;
        for (int i = 0; i < NUM_LINES; i++)
        begin
            if (trig[i])
                chan_on_nxt = apply_act(cfg_r[i].act, chan_on_nxt, cfg_r[i].chan_mask); // [RQ11]
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            chan_on_r <= '0;
        else
            chan_on_r <= chan_on_nxt;                                      // [RQ11]
    end

    // ************************************************************
    // Output lines
    // ************************************************************
    logic [NUM_LINES-1:0] out_r;
    logic [NUM_LINES-1:0] oe_r;
    logic [NUM_CHANS-1:0] sel_r;

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            out_r <= '0;
            oe_r  <= '0;
        end
        else
        begin
            for (int i = 0; i < NUM_LINES; i++)
            begin
                oe_r[i]  <= cfg_r[i].is_output && line_enable_in[i];
                out_r[i] <= (cond_met_in[i] && line_enable_in[i]) ^ cfg_r[i].polarity_neg; // [RQ13] [RQ17]
            end
        end
    end

    logic [NUM_CHANS-1:0] sel_nxt;

    always_comb
    begin
        sel_nxt = '0;
        for (int i = 0; i < NUM_LINES; i++)
        begin
            if (cfg_r[i].is_output)
                sel_nxt = sel_nxt | cfg_r[i].chan_mask;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            sel_r <= '0;
        else
            sel_r <= sel_nxt;                                              // [RQ12]
    end

    assign io_lines_o_out          = out_r;
    assign io_lines_oe_out         = oe_r;
    assign cfg_reject_out          = reject_r;
    assign supply_channels_on_out  = chan_on_r;
    assign supply_channels_sel_out = sel_r;

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_rise0;
        !sync2_r[0] ##1 sync2_r[0];
    endsequence

    property p_rise_on;
        @(posedge clk_in) disable iff (reset_in)
        (cfg_r[0].det == eio_pkg::EIO_DET_RISE && !cfg_r[0].is_output && line_enable_in[0]
         && cfg_r[0].act == eio_pkg::EIO_ACT_ON && trig[0]
         && (trig[NUM_LINES-1:1] == '0))  // Later lines may override line 0
        |=> ((chan_on_r & cfg_r[0].chan_mask) == $past(cfg_r[0].chan_mask));
    endproperty
    a_rise_on: assert property (p_rise_on) else $error("on action missed"); // [RQ11]

    property p_rise_only;
        @(posedge clk_in) disable iff (reset_in)
        (cfg_r[0].det == eio_pkg::EIO_DET_RISE && trig[0]) |-> (sync2_r[0] && !prev_r[0]);
    endproperty
    a_rise_only: assert property (p_rise_only) else $error("rise misdetect"); // [RQ2]

    property p_fall_only;
        @(posedge clk_in) disable iff (reset_in)
        (cfg_r[0].det == eio_pkg::EIO_DET_FALL && trig[0]) |-> $fell(sync2_r[0]);
    endproperty
    a_fall_only: assert property (p_fall_only) else $error("fall misdetect"); // [RQ3]

    property p_high;
        @(posedge clk_in) disable iff (reset_in)
        (cfg_r[0].det == eio_pkg::EIO_DET_HIGH && line_enable_in[0] && !cfg_r[0].is_output)
        |-> (trig[0] == sync2_r[0]);
    endproperty
    a_high: assert property (p_high) else $error("high level misdetect"); // [RQ4]

    property p_low;
        @(posedge clk_in) disable iff (reset_in)
        (cfg_r[0].det == eio_pkg::EIO_DET_LOW && line_enable_in[0] && !cfg_r[0].is_output)
        |-> (trig[0] == !sync2_r[0]);
    endproperty
    a_low: assert property (p_low) else $error("low level misdetect"); // [RQ5]

    property p_any;
        @(posedge clk_in) disable iff (reset_in)
        (cfg_r[0].det == eio_pkg::EIO_DET_ANY && line_enable_in[0] && !cfg_r[0].is_output
         && $changed(sync2_r[0])) |-> trig[0];
    endproperty
    a_any: assert property (p_any) else $error("change missed"); // [RQ6]

    property p_mask_nonempty;
        @(posedge clk_in) disable iff (reset_in)
        (cfg_r[0].chan_mask != eio_pkg::CHAN_NONE);
    endproperty
    a_mask_nonempty: assert property (p_mask_nonempty) else $error("empty mask"); // [RQ10]

    property p_out_one;
        @(posedge clk_in) disable iff (reset_in)
        cfg_r[0].is_output |-> $onehot(cfg_r[0].chan_mask);
    endproperty
    a_out_one: assert property (p_out_one) else $error("output mask not one-hot"); // [RQ12]

    property p_locked;
        @(posedge clk_in) disable iff (reset_in)
        (line_enable_in[0] && !cfg_write_in[0]) ##1 line_enable_in[0]
        |-> $stable(cfg_r[0]);
    endproperty
    a_locked: assert property (p_locked) else $error("config changed while enabled"); // [RQ16]

    property p_no_toggle_any;
        @(posedge clk_in) disable iff (reset_in)
        !(cfg_r[0].det == eio_pkg::EIO_DET_ANY && !cfg_r[0].is_output
          && cfg_r[0].act == eio_pkg::EIO_ACT_TOGGLE);
    endproperty
    a_no_toggle_any: assert property (p_no_toggle_any) else $error("toggle with change"); // [RQ7]

    property p_out_pol;
        @(posedge clk_in) disable iff (reset_in)
        s_rise0 or 1'b1 |=> (out_r[0] == ($past(cond_met_in[0] && line_enable_in[0])
                                          ^ $past(cfg_r[0].polarity_neg)));
    endproperty
    a_out_pol: assert property (p_out_pol) else $error("output level wrong"); // [RQ13]

endmodule : eio_trigger_map

// File: verification/eio_contact.sv
`timescale 1ns/1ps
// ************************************************************
// External contact bank on the io lines
// ************************************************************
module eio_contact (
    input  wire logic       clk_in,
    input  wire logic [4:0] want_in,
    input  wire logic       slow_in,
    output logic      [4:0] level_out
);
    logic [1:0] pace_r;

    initial
    begin
        level_out = 5'h0;
        pace_r    = 2'h0;
    end

    // Slow mode mimics a sluggish relay: moves only every third cycle
    always @(posedge clk_in)
    begin
        pace_r <= (pace_r == 2'h2) ? 2'h0 : pace_r + 2'h1;
        if (!slow_in || pace_r == 2'h0)
        begin
            level_out <= want_in;
        end
    end
endmodule : eio_contact

// File: verification/eio_trigger_map_tb.sv
`timescale 1ns/1ps
module eio_trigger_map_tb;
    localparam eio_pkg::eio_cfg_t CFG_RST = '{1'b0, eio_pkg::EIO_DET_RISE, eio_pkg::EIO_ACT_ON,
                                             4'h1, 1'b0};
    logic               clk_in, reset_in, cfg_line_is_output_in, cfg_polarity_neg_in;
    logic               slow, rnd_on, armed;
    logic         [4:0] line_enable_in, cfg_write_in, cond_met_in, io_lines_i_in, want, lvl;
    logic         [4:0] io_lines_o_out, io_lines_oe_out, cfg_reject_out, en_prev;
    logic         [4:0] exp_o, exp_oe, exp_rej, out_m, s1, s2, s3;
    logic         [3:0] cfg_chan_mask_in, chan_on_in, on_out, sel_out, exp_on, exp_sel;
    eio_pkg::eio_det_t  cfg_det_in;
    eio_pkg::eio_act_t  cfg_act_in;
    eio_pkg::eio_cfg_t  cfg_m [5];
    logic        [31:0] seed_r;
    int                 num_errors, cmp_count, quiet;

    eio_trigger_map u_eio_trigger_map (.clk_in(clk_in), .reset_in(reset_in),
        .line_enable_in(line_enable_in), .cfg_write_in(cfg_write_in),
        .cfg_line_is_output_in(cfg_line_is_output_in), .cfg_det_in(cfg_det_in),
        .cfg_act_in(cfg_act_in), .cfg_chan_mask_in(cfg_chan_mask_in),
        .cfg_polarity_neg_in(cfg_polarity_neg_in), .cond_met_in(cond_met_in),
        .chan_on_in(chan_on_in), .io_lines_i_in(io_lines_i_in), .io_lines_o_out(io_lines_o_out),
        .io_lines_oe_out(io_lines_oe_out), .cfg_reject_out(cfg_reject_out),
        .supply_channels_on_out(on_out), .supply_channels_sel_out(sel_out));
    eio_contact u_eio_contact (.clk_in(clk_in), .want_in(want), .slow_in(slow), .level_out(lvl));

    // Wire level: design drives where its output enable is set, contact elsewhere
    assign io_lines_i_in = (io_lines_oe_out & io_lines_o_out) | (~io_lines_oe_out & lvl);

    initial
    begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        xs = x ^ (x << 5);
    endfunction : xs

    function automatic logic [3:0] apply_act(input logic [3:0] on, input eio_pkg::eio_act_t a,
                                             input logic [3:0] m);
        case (a)
            eio_pkg::EIO_ACT_OFF: apply_act = on & ~m;
            eio_pkg::EIO_ACT_ON:  apply_act = on | m;
            default:              apply_act = on ^ m;
        endcase
    endfunction : apply_act

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] expv);
        cmp_count++;
        if (seen !== expv)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, expv, seen);
        end
    endtask : check

    task automatic print_verdict();
        $display("compares %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    task automatic wr(input logic [4:0] lines, input eio_pkg::eio_cfg_t c);
        @(posedge clk_in);
        cfg_write_in          <= lines;
        cfg_line_is_output_in <= c.is_output;
        cfg_det_in            <= c.det;
        cfg_act_in            <= c.act;
        cfg_chan_mask_in      <= c.chan_mask;
        cfg_polarity_neg_in   <= c.polarity_neg;
        @(posedge clk_in);
        cfg_write_in <= 5'h00;
    endtask : wr

    task automatic run(input logic [4:0] en, input int n);
        @(posedge clk_in);
        line_enable_in <= en;
        rnd_on         <= 1'b1;
        repeat (n) @(posedge clk_in);
        rnd_on         <= 1'b0;
        line_enable_in <= 5'h00;
    endtask : run

    // ************************************************************
    // Random stimulus
    // ************************************************************
    always @(posedge clk_in)
    begin
        if (rnd_on)
        begin
            seed_r = xs(seed_r);
            chan_on_in  <= seed_r[3:0];
            cond_met_in <= seed_r[8:4];
            if (seed_r[30:29] == 2'h0)
                want <= seed_r[13:9];
        end
    end

    // ************************************************************
    // Reference model
    // ************************************************************
    always @(posedge clk_in)
    begin : ref_model
        logic              t;
        eio_pkg::eio_cfg_t c;
        logic        [3:0] keep;
        c = '{cfg_line_is_output_in, cfg_det_in, cfg_act_in, cfg_chan_mask_in, cfg_polarity_neg_in};
        quiet = (reset_in || |cfg_write_in || line_enable_in != en_prev) ? 4 : (quiet > 0) ? quiet - 1 : 0;
        en_prev = line_enable_in;
        exp_on = chan_on_in;
        exp_sel = 4'h0;
        for (int i = 0; i < 5; i++)
        begin
            case (cfg_m[i].det)
                eio_pkg::EIO_DET_RISE: t = s2[i] & ~s3[i];
                eio_pkg::EIO_DET_FALL: t = ~s2[i] & s3[i];
                eio_pkg::EIO_DET_HIGH: t = s2[i];
                eio_pkg::EIO_DET_LOW:  t = ~s2[i];
                default:               t = s2[i] ^ s3[i];
            endcase
            // Later lines win, as the line order 0..4 says
            if (t && line_enable_in[i] && !cfg_m[i].is_output)
                exp_on = apply_act(exp_on, cfg_m[i].act, cfg_m[i].chan_mask);
            out_m[i] = cfg_m[i].is_output;
            exp_oe[i] = cfg_m[i].is_output & line_enable_in[i];
            exp_o[i] = (cond_met_in[i] & line_enable_in[i]) ^ cfg_m[i].polarity_neg;
            if (cfg_m[i].is_output)
                exp_sel = exp_sel | cfg_m[i].chan_mask;
            exp_rej[i] = cfg_write_in[i] && (line_enable_in[i] || (!c.is_output &&
                (c.chan_mask == 4'h0 || (c.det == eio_pkg::EIO_DET_ANY &&
                 c.act == eio_pkg::EIO_ACT_TOGGLE))));
            if (reset_in)
                cfg_m[i] = CFG_RST;
            else if (cfg_write_in[i] && !exp_rej[i])
            begin
                // Empty output mask keeps the channel held before the write
                keep = cfg_m[i].chan_mask;
                cfg_m[i] = c;
                if (c.is_output)
                    cfg_m[i].chan_mask = (c.chan_mask == 4'h0) ? keep
                                       : c.chan_mask & (~c.chan_mask + 4'h1);
            end
        end
        s3 = reset_in ? 5'h00 : s2;
        s2 = reset_in ? 5'h00 : s1;
        s1 = reset_in ? 5'h00 : io_lines_i_in;
    end

    always @(negedge clk_in)
    begin
        if (armed && !reset_in)
        begin
            check("reject", 8'(cfg_reject_out), 8'(exp_rej));
            if (quiet == 0)
            begin
                check("chan_on", 8'(on_out), 8'(exp_on));
                check("oe", 8'(io_lines_oe_out), 8'(exp_oe));
                check("level", 8'(io_lines_o_out & out_m), 8'(exp_o & out_m));
                if ((out_m & ~line_enable_in) == 5'h00)
                    check("sel", 8'(sel_out), 8'(exp_sel));
            end
        end
    end

    initial
    begin
        #400000;
        num_errors++;
        print_verdict();
    end

    initial
    begin
        {reset_in, rnd_on, armed, slow} = 4'h8;
        {line_enable_in, cfg_write_in, cond_met_in, want} = 20'h0;
        {cfg_line_is_output_in, cfg_polarity_neg_in, cfg_chan_mask_in, chan_on_in} = 10'h0;
        cfg_det_in = eio_pkg::EIO_DET_RISE;
        cfg_act_in = eio_pkg::EIO_ACT_ON;
        seed_r     = 32'hf1b2;
        en_prev    = 5'h00;
        repeat (4) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        armed          <= 1'b1;
        line_enable_in <= 5'h01;
        @(negedge clk_in);
        check("oe_rst", 8'(io_lines_oe_out), 8'h00);
        // Refused and boundary writes
        wr(5'h01, CFG_RST);
        line_enable_in <= 5'h00;
        wr(5'h02, '{1'b0, eio_pkg::EIO_DET_RISE, eio_pkg::EIO_ACT_ON, 4'h0, 1'b0});
        wr(5'h02, '{1'b0, eio_pkg::EIO_DET_ANY, eio_pkg::EIO_ACT_TOGGLE, 4'hf, 1'b0});
        wr(5'h02, '{1'b0, eio_pkg::EIO_DET_ANY, eio_pkg::EIO_ACT_OFF, 4'hf, 1'b0});
        // Every detection method, one line each, overlapping masks
        for (int i = 0; i < 5; i++)
            wr(5'h01 << i, '{1'b0, eio_pkg::eio_det_t'(i), eio_pkg::eio_act_t'(i % 3),
                             (i == 4) ? 4'hf : 4'(i + 1), 1'b0});
        run(5'h1f, 300);
        slow <= 1'b1;
        run(5'h1f, 200);
        slow <= 1'b0;
        // Output lines: multi-bit mask keeps lowest, then empty and new selections
        wr(5'h08, '{1'b1, eio_pkg::EIO_DET_RISE, eio_pkg::EIO_ACT_ON, 4'h6, 1'b1});
        wr(5'h10, '{1'b1, eio_pkg::EIO_DET_RISE, eio_pkg::EIO_ACT_ON, 4'h8, 1'b0});
        run(5'h1f, 200);
        wr(5'h08, '{1'b1, eio_pkg::EIO_DET_RISE, eio_pkg::EIO_ACT_ON, 4'h0, 1'b0});
        run(5'h18, 50);
        wr(5'h08, '{1'b1, eio_pkg::EIO_DET_RISE, eio_pkg::EIO_ACT_ON, 4'h1, 1'b1});
        run(5'h1f, 50);
        repeat (4) @(posedge clk_in);
        print_verdict();
    end
endmodule : eio_trigger_map_tb
